//--- logic/flag_cell.sv
/*
 * One event flag with selectable hold behaviour.
 * Assumes the event and clear inputs are on sys_clk_i.
 */
`timescale 1ns/1ns
module flag_cell
(
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic soft_rst_i,
    input  wire logic hold_i,
    input  wire logic set_i,
    input  wire logic level_i,
    input  wire logic follow_i,
    input  wire logic pkt_start_i,
    input  wire logic clear_i,
    output logic      flag_o
);
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            flag_o <= 1'b0;
        else if (soft_rst_i)
            flag_o <= 1'b0;
        else if (hold_i)
        begin
            if (set_i || (follow_i && level_i))
                flag_o <= 1'b1;
            else if (clear_i)
                flag_o <= 1'b0;
        end
        else if (follow_i)
            flag_o <= level_i;
        else if (set_i)
            flag_o <= 1'b1;
        else if (pkt_start_i || clear_i)
            flag_o <= 1'b0;
    end
endmodule

//--- logic/usb_ism_consts.svh
/*
 * Register offsets, field positions and reset values of the USB
 * interface state machine register block.
 * Assumes it is included once per compilation unit by bare name.
 */
`ifndef USB_ISM_CONSTS_SVH
`define USB_ISM_CONSTS_SVH

`define ISM_OFS_RESET      8'h00
`define ISM_OFS_DEV_ADDR   8'h08
`define ISM_OFS_FUNC_CTRL  8'h0c
`define ISM_OFS_OTG_CTRL   8'h10
`define ISM_OFS_OTG_STAT   8'h14
`define ISM_OFS_SERIAL     8'h18
`define ISM_OFS_FLAGS      8'h1c
`define ISM_OFS_HOLD_SEL   8'h20
`define ISM_OFS_PORT_MASK  8'h24
`define ISM_OFS_FRAME      8'h28
`define ISM_OFS_PID        8'h2c
`define ISM_OFS_ENDPOINT   8'h30
`define ISM_OFS_EP_MARK    8'h34

`define ISM_FUNC_RESET     5'h07
`define ISM_SERIAL_RESET   4'h2
`define ISM_EP_MARK_OR     5'h10

`define ISM_FLAG_TOKEN     6
`define ISM_FLAG_SE0       5
`define ISM_FLAG_K         4
`define ISM_FLAG_J         3
`define ISM_FLAG_CRC16     2
`define ISM_FLAG_RXACT     1
`define ISM_FLAG_RXERR     0

`endif

//--- logic/usb_ism_pkg.sv
/*
 * Types shared by the USB interface state machine register block.
 * Assumes nothing of its surroundings.
 */
package usb_ism_pkg;
    typedef logic [6:0]  flags_t;
    typedef logic [1:0]  line_state_t;
    typedef logic [31:0] word_t;
    typedef enum logic [2:0]
    {
        PKT_IDLE  = 3'b001,
        PKT_BUSY  = 3'b010,
        PKT_DONE  = 3'b100
    } pkt_state_e;
endpackage

//--- logic/usb_ism_regs.sv
/*
 * Control and status registers of the USB interface state machine,
 * between processor register ports and a UTMI+ transceiver.
 * Assumes 32-bit register accesses on sys_clk_i, packet events from
 * the decoder on the same clock, and raw transceiver status pins.
 */
`timescale 1ns/1ns
`include "usb_ism_consts.svh"
module usb_ism_regs
(
    input  wire logic                     sys_clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic [7:0]               reg_addr_i,
    input  wire logic                     reg_wr_i,
    input  wire usb_ism_pkg::word_t       reg_wdata_i,
    output usb_ism_pkg::word_t            reg_rdata_o,
    input  wire logic                     pkt_start_i,
    input  wire logic [6:0]               pkt_addr_i,
    input  wire logic                     tok_valid_i,
    input  wire logic                     tok_crc_ok_i,
    input  wire logic                     tok_pid_ok_i,
    input  wire logic [3:0]               tok_pid_i,
    input  wire logic [3:0]               tok_ep_i,
    input  wire logic                     crc16_fail_i,
    input  wire logic                     frame_load_i,
    input  wire logic [10:0]              frame_val_i,
    input  wire usb_ism_pkg::line_state_t line_state_i,
    input  wire logic                     rx_active_i,
    input  wire logic                     rx_error_i,
    input  wire logic [5:0]               otg_stat_i,
    input  wire logic [2:0]               serial_rx_i,
    output logic                          pkt_accept_o,
    output logic [4:0]                    rx_ep_o,
    output logic                          ism_reset_o,
    output logic [2:0]                    opmode_o,
    output logic                          term_select_o,
    output logic                          xcvr_select_o,
    output logic [6:0]                    otg_ctrl_o,
    output logic                          tx_se0_o,
    output logic                          tx_data_o,
    output logic                          tx_enable_n_o,
    output logic                          fsls_serial_o,
    output logic                          flag_port_a_o,
    output logic                          flag_port_b_o,
    output logic                          flag_port_c_o,
    output logic                          flag_port_d_o
);
    import usb_ism_pkg::*;

    logic [6:0]  dev_addr_reg;
    logic [4:0]  func_reg;
    logic [6:0]  otg_reg;
    logic [3:0]  serial_reg;
    flags_t      hold_reg;
    word_t       mask_reg;
    logic [10:0] frame_reg;
    logic [3:0]  pid_reg;
    logic [4:0]  ep_reg;
    logic [15:0] ep_mark_reg;
    logic [5:0]  otg_meta_reg, otg_sync_reg;
    logic [3:0]  rx_meta_reg, rx_sync_reg;
    logic [2:0]  ser_meta_reg, ser_sync_reg;
    flags_t      flags, set_vec, lvl_vec, clr_vec;
    logic        soft_rst, addr_hit, tok_good, wr_flags;
    logic [4:0]  rx_ep_next;

    assign soft_rst = reg_wr_i && (reg_addr_i == `ISM_OFS_RESET);
    assign ism_reset_o = soft_rst;

    // Two-stage synchronisers for transceiver status pins.
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            otg_meta_reg <= 6'h00;
            otg_sync_reg <= 6'h00;
            rx_meta_reg  <= 4'h0;
            rx_sync_reg  <= 4'h0;
            ser_meta_reg <= 3'h0;
            ser_sync_reg <= 3'h0;
        end
        else
        begin
            otg_meta_reg <= otg_stat_i;
            otg_sync_reg <= otg_meta_reg;
            rx_meta_reg  <= {line_state_i, rx_active_i, rx_error_i};
            rx_sync_reg  <= rx_meta_reg;
            ser_meta_reg <= serial_rx_i;
            ser_sync_reg <= ser_meta_reg;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dev_addr_reg <= 7'h00;
            func_reg     <= `ISM_FUNC_RESET;
            otg_reg      <= 7'h00;
            serial_reg   <= `ISM_SERIAL_RESET;
            hold_reg     <= 7'h00;
            mask_reg     <= 32'h0000_0000;
            ep_mark_reg  <= 16'h0000;
        end
        else if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                `ISM_OFS_DEV_ADDR:  dev_addr_reg <= reg_wdata_i[6:0];
                `ISM_OFS_FUNC_CTRL: func_reg <= reg_wdata_i[4:0];
                `ISM_OFS_OTG_CTRL:
                    otg_reg <= {reg_wdata_i[7:6], reg_wdata_i[4:0]};
                `ISM_OFS_SERIAL:    serial_reg <= reg_wdata_i[3:0];
                `ISM_OFS_HOLD_SEL:  hold_reg <= reg_wdata_i[6:0];
                `ISM_OFS_PORT_MASK: mask_reg <= reg_wdata_i;
                `ISM_OFS_EP_MARK:   ep_mark_reg <= reg_wdata_i[15:0];
                default:            ;
            endcase
        end
    end

    assign opmode_o      = func_reg[4:2];
    assign term_select_o = func_reg[1];
    assign xcvr_select_o = func_reg[0];
    assign otg_ctrl_o    = otg_reg;
    assign tx_se0_o      = serial_reg[3];
    assign tx_data_o     = serial_reg[2];
    assign tx_enable_n_o = serial_reg[1];
    assign fsls_serial_o = serial_reg[0];

    assign addr_hit = (pkt_addr_i == dev_addr_reg);
    assign tok_good = tok_valid_i && tok_crc_ok_i && tok_pid_ok_i
                      && addr_hit;

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pkt_accept_o <= 1'b0;
        else
            pkt_accept_o <= pkt_start_i && addr_hit && !soft_rst;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            frame_reg <= 11'h000;
        else if (soft_rst)
            frame_reg <= 11'h000;
        else if (reg_wr_i && reg_addr_i == `ISM_OFS_FRAME)
            frame_reg <= reg_wdata_i[10:0];
        else if (frame_load_i)
            frame_reg <= frame_val_i;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pid_reg <= 4'h0;
            ep_reg  <= 5'h00;
            rx_ep_o <= 5'h00;
        end
        else if (soft_rst)
        begin
            pid_reg <= 4'h0;
            ep_reg  <= 5'h00;
            rx_ep_o <= 5'h00;
        end
        else if (tok_good)
        begin
            pid_reg <= tok_pid_i;
            ep_reg  <= {1'b1, tok_ep_i};
            rx_ep_o <= rx_ep_next;
        end
    end

    always_comb
    begin
        rx_ep_next = {1'b0, tok_ep_i};
        if (ep_mark_reg[tok_ep_i])
            rx_ep_next = rx_ep_next | `ISM_EP_MARK_OR;
    end

    always_comb
    begin
        set_vec = 7'h00;
        set_vec[`ISM_FLAG_TOKEN] = tok_good;
        set_vec[`ISM_FLAG_SE0]   = (rx_sync_reg[3:2] == 2'b00);
        set_vec[`ISM_FLAG_K]     = (rx_sync_reg[3:2] == 2'b10);
        set_vec[`ISM_FLAG_J]     = (rx_sync_reg[3:2] == 2'b01);
        set_vec[`ISM_FLAG_CRC16] = crc16_fail_i;
    end

    assign lvl_vec  = {5'h00, rx_sync_reg[1], rx_sync_reg[0]};
    assign wr_flags = reg_wr_i && (reg_addr_i == `ISM_OFS_FLAGS);
    assign clr_vec  = wr_flags ? reg_wdata_i[6:0] : 7'h00;

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++)
        begin : g_flag
            flag_cell u_flag
            (
                .sys_clk_i   (sys_clk_i),
                .rst_n_i     (rst_n_i),
                .soft_rst_i  (soft_rst),
                .hold_i      (hold_reg[gi]),
                .set_i       (set_vec[gi]),
                .level_i     (lvl_vec[gi]),
                .follow_i    (gi <= 1),
                .pkt_start_i (pkt_start_i),
                .clear_i     (clr_vec[gi]),
                .flag_o      (flags[gi])
            );
        end
    endgenerate

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            flag_port_a_o <= 1'b0;
            flag_port_b_o <= 1'b0;
            flag_port_c_o <= 1'b0;
            flag_port_d_o <= 1'b0;
        end
        else
        begin
            flag_port_a_o <= |(flags & mask_reg[6:0]);
            flag_port_b_o <= |(flags & mask_reg[14:8]);
            flag_port_c_o <= |(flags & mask_reg[22:16]);
            flag_port_d_o <= |(flags & mask_reg[30:24]);
        end
    end

    // OTG status; serial receive; reserved zero
    always_comb
    begin
        reg_rdata_o = 32'h0000_0000;
        unique case (reg_addr_i)
            `ISM_OFS_DEV_ADDR:  reg_rdata_o[6:0] = dev_addr_reg;
            `ISM_OFS_FUNC_CTRL: reg_rdata_o[4:0] = func_reg;
            `ISM_OFS_OTG_CTRL:
                reg_rdata_o[7:0] = {otg_reg[6:5], 1'b0, otg_reg[4:0]};
            `ISM_OFS_OTG_STAT:  reg_rdata_o[5:0] = otg_sync_reg;
            `ISM_OFS_SERIAL:
                reg_rdata_o[6:0] = {ser_sync_reg, serial_reg};
            `ISM_OFS_FLAGS:     reg_rdata_o[6:0] = flags;
            `ISM_OFS_HOLD_SEL:  reg_rdata_o[6:0] = hold_reg;
            `ISM_OFS_PORT_MASK: reg_rdata_o = mask_reg;
            `ISM_OFS_FRAME:     reg_rdata_o[10:0] = frame_reg;
            `ISM_OFS_PID:       reg_rdata_o[3:0] = pid_reg;
            `ISM_OFS_ENDPOINT:  reg_rdata_o[4:0] = ep_reg;
            `ISM_OFS_EP_MARK:   reg_rdata_o[15:0] = ep_mark_reg;
            default:            reg_rdata_o = 32'h0000_0000;
        endcase
    end

    default clocking cb_sys @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_token_flag: assert property (tok_good && !soft_rst |=> flags[6])
        else $error("token flag not set");

    a_soft_reset: assert property (
        soft_rst |=> (ep_reg == 5'h00) && (frame_reg == 11'h000))
        else $error("soft reset missed state");

    a_hold_keep: assert property (
        flags[2] && hold_reg[2] && !clr_vec[2] && !soft_rst |=> flags[2])
        else $error("held flag lost");

    a_auto_clear: assert property (
        pkt_start_i && !hold_reg[2] && !crc16_fail_i |=> !flags[2])
        else $error("flag not cleared by packet");

    a_port_a_or: assert property (
        |(flags & mask_reg[6:0]) |=> flag_port_a_o)
        else $error("port a not raised");

    a_ep_valid: assert property (
        tok_good && !soft_rst |=> ep_reg == {1'b1, $past(tok_ep_i)})
        else $error("endpoint not captured");

    a_ep_mark: assert property (
        tok_good && !soft_rst && ep_mark_reg[tok_ep_i] |=> rx_ep_o[4])
        else $error("mark bit missing");

    a_addr_filter: assert property (
        pkt_start_i && !addr_hit |=> !pkt_accept_o)
        else $error("foreign packet accepted");

    // free rx active flag follows level
    a_rx_follow: assert property (
        !soft_rst && !hold_reg[1] |=> flags[1] == $past(rx_sync_reg[1]))
        else $error("rx active flag stale");
endmodule

//--- sim/usb_ism_regs_tb.sv
/*
 * Self-checking bench for the interface state machine registers.
 * Assumes the transceiver stand-in of utmi_xcvr_model.sv.
 */
`timescale 1ns/1ns
module usb_ism_regs_tb;
    import usb_ism_pkg::*;
    logic        sys_clk_i = 1'h0, rst_n_i = 1'h0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic        reg_wr_i = 1'h0;
    word_t       reg_wdata_i = '0, reg_rdata_o, d;
    logic        pkt_start_i = 1'h0, tok_valid_i = 1'h0, crc16_fail_i = 1'h0;
    logic        frame_load_i = 1'h0, tok_crc_ok_i = 1'h0, tok_pid_ok_i = 1'h0;
    logic [6:0]  pkt_addr_i = 7'h00;
    logic [3:0]  tok_pid_i = 4'h0, tok_ep_i = 4'h0;
    logic [10:0] frame_val_i = 11'h5a3;
    line_state_t line_state_i;
    logic        rx_active_i, rx_error_i, pkt_accept_o, ism_reset_o;
    logic [5:0]  otg_stat_i;
    logic [2:0]  serial_rx_i, opmode_o;
    logic [4:0]  rx_ep_o;
    logic [6:0]  otg_ctrl_o;
    logic        term_select_o, xcvr_select_o, tx_se0_o, tx_data_o;
    logic        tx_enable_n_o, fsls_serial_o;
    logic        flag_port_a_o, flag_port_b_o, flag_port_c_o, flag_port_d_o;
    int          bad_count = 0, num_checks = 0, cyc = 0;
    logic [7:0]  rw_a [8] = '{8'h08, 8'h0c, 8'h10, 8'h18,
                              8'h20, 8'h24, 8'h28, 8'h34};
    word_t       rw_m [8] = '{32'h7f, 32'h1f, 32'hdf, 32'h1f,
                              32'h7f, 32'h7f7f7f7f, 32'h7ff, 32'hffff};
    word_t       rs [8] = '{32'h0, 32'h7, 32'h0, 32'h12,
                            32'h0, 32'h0, 32'h0, 32'h0};

    usb_ism_regs i_usb_ism_regs (.*);
    utmi_xcvr_model i_utmi_xcvr_model
    (
        .sys_clk_i(sys_clk_i), .tx_se0_i(tx_se0_o), .tx_data_i(tx_data_o),
        .tx_enable_n_i(tx_enable_n_o), .line_state_o(line_state_i),
        .rx_active_o(rx_active_i), .rx_error_o(rx_error_i),
        .otg_stat_o(otg_stat_i), .serial_rx_o(serial_rx_i)
    );

    initial
    begin
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input word_t e, input word_t g);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input word_t v);
        @(posedge sys_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= v;
        reg_wr_i    <= 1'h1;
        #1;
        if (a == 8'h00)
            chk("soft_reset_pulse", 1, ism_reset_o);
        @(posedge sys_clk_i);
        reg_wr_i <= 1'h0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        #1;
        d = reg_rdata_o;
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input word_t e);
        rd(a);
        chk(nm, e, d);
    endtask
    task automatic ev(input logic [3:0] k, input logic [6:0] a,
                      input logic ok, input logic [3:0] ep);
        @(posedge sys_clk_i);
        {pkt_start_i, tok_valid_i, crc16_fail_i, frame_load_i} <= k;
        pkt_addr_i   <= a;
        tok_crc_ok_i <= ok;
        tok_pid_ok_i <= 1'h1;
        tok_pid_i    <= ep ^ 4'h9;
        tok_ep_i     <= ep;
        @(posedge sys_clk_i);
        {pkt_start_i, tok_valid_i, crc16_fail_i, frame_load_i} <= 4'h0;
        #1;
    endtask

    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'h1;
        chk("opmode", 3'h1, opmode_o);
        chk("term_xcvr", 2'h3, {term_select_o, xcvr_select_o});
        chk("tx_enable_n", 1, tx_enable_n_o);
        chk("otg_ctrl", 0, otg_ctrl_o);
        w(4);
        foreach (rw_a[i]) rdchk("reset_value", rw_a[i], rs[i]);
        rdchk("pid_reset", 8'h2c, 0);
        rdchk("ep_reset", 8'h30, 0);
        rdchk("otg_stat_reset", 8'h14, 0);
        foreach (rw_a[i])
        begin
            wr(rw_a[i], rw_a[i] == 8'h24 ? 32'h7f7f7f7f : '1);
            w(3);
            rdchk("rw_ones", rw_a[i], rw_m[i]);
        end
        chk("ctrl_ones", 16'hffff, {opmode_o, term_select_o, xcvr_select_o,
            otg_ctrl_o, tx_se0_o, tx_data_o, tx_enable_n_o, fsls_serial_o});
        foreach (rw_a[i])
        begin
            wr(rw_a[i], '0);
            w(3);
            rdchk("rw_zero", rw_a[i], rw_a[i] == 8'h18 ? 32'h20 : 0);
        end
        chk("ctrl_zero", 0, {opmode_o, term_select_o, xcvr_select_o,
            otg_ctrl_o, tx_se0_o, tx_data_o, fsls_serial_o});
        wr(8'h3c, '1);
        rdchk("unmapped", 8'h3c, 0);
        wr(8'h2c, '1);
        rdchk("pid_read_only", 8'h2c, 0);
        wr(8'h0c, 32'h9);
        chk("func_fields", 5'h09, {opmode_o, term_select_o, xcvr_select_o});
        wr(8'h10, 32'hc5);
        chk("otg_fields", 7'h65, otg_ctrl_o);
        wr(8'h18, 32'hd);
        chk("serial_out", 4'hd, {tx_se0_o, tx_data_o, tx_enable_n_o,
            fsls_serial_o});
        w(4);
        rdchk("serial_se0", 8'h18, 32'h0d);
        wr(8'h18, 32'h5);
        w(4);
        rdchk("serial_data", 8'h18, 32'h55);
        wr(8'h18, 32'h2);
        w(4);
        rdchk("serial_idle", 8'h18, 32'h12);
        i_utmi_xcvr_model.set_pins(2'h1, 1'h0, 1'h0, 6'h2a);
        w(4);
        rdchk("otg_stat", 8'h14, 32'h2a);
        wr(8'h14, '1);
        rdchk("otg_stat_ro", 8'h14, 32'h2a);
        // Line symbols SE0, K and J land on flags 5, 4 and 3.
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h1c, 32'h7f);
            i_utmi_xcvr_model.set_pins(i == 0 ? 2'h0 : 2'h3 - i[1:0],
                                       1'h0, 1'h0, 6'h15);
            w(4);
            rd(8'h1c);
            chk("line_flag", 1, d[5 - i]);
        end
        i_utmi_xcvr_model.set_pins(2'h1, 1'h1, 1'h1, 6'h15);
        w(4);
        rd(8'h1c);
        chk("rx_flags_high", 2'h3, d[1:0]);
        i_utmi_xcvr_model.set_pins(2'h1, 1'h0, 1'h0, 6'h15);
        w(4);
        rd(8'h1c);
        chk("rx_flags_low", 2'h0, d[1:0]);
        wr(8'h08, 32'h2a);
        wr(8'h34, 32'h20);
        ev(4'h8, 7'h2a, 1'h1, 4'h0);
        chk("accept_match", 1, pkt_accept_o);
        ev(4'h8, 7'h15, 1'h1, 4'h0);
        chk("accept_other", 0, pkt_accept_o);
        wr(8'h1c, 32'h7f);
        ev(4'h4, 7'h2a, 1'h1, 4'h5);
        chk("rx_ep_marked", 5'h15, rx_ep_o);
        rd(8'h1c);
        chk("token_flag", 1, d[6]);
        rdchk("pid", 8'h2c, 32'hc);
        rdchk("endpoint", 8'h30, 32'h15);
        ev(4'h4, 7'h2a, 1'h1, 4'h3);
        chk("rx_ep_plain", 5'h03, rx_ep_o);
        wr(8'h1c, 32'h40);
        ev(4'h4, 7'h2a, 1'h0, 4'h7);
        ev(4'h4, 7'h15, 1'h1, 4'h7);
        rd(8'h1c);
        chk("token_rejected", 0, d[6]);
        rdchk("endpoint_kept", 8'h30, 32'h13);
        wr(8'h24, 32'h04000400);
        ev(4'h2, 7'h2a, 1'h1, 4'h0);
        w(1);
        chk("ports_bd", 4'h5, {flag_port_a_o, flag_port_b_o,
            flag_port_c_o, flag_port_d_o});
        rd(8'h1c);
        chk("crc16_flag", 1, d[2]);
        wr(8'h24, 32'h00040004);
        w(1);
        chk("ports_ac", 4'ha, {flag_port_a_o, flag_port_b_o,
            flag_port_c_o, flag_port_d_o});
        ev(4'h8, 7'h2a, 1'h1, 4'h0);
        w(1);
        chk("ports_cleared", 0, {flag_port_a_o, flag_port_c_o});
        wr(8'h20, 32'h4);
        ev(4'h2, 7'h2a, 1'h1, 4'h0);
        ev(4'h8, 7'h2a, 1'h1, 4'h0);
        rd(8'h1c);
        chk("held_flag", 1, d[2]);
        wr(8'h1c, 32'h4);
        rd(8'h1c);
        chk("held_cleared", 0, d[2]);
        ev(4'h1, 7'h2a, 1'h1, 4'h0);
        rdchk("frame_load", 8'h28, 32'h5a3);
        ev(4'h6, 7'h2a, 1'h1, 4'h5);
        wr(8'h00, 32'h1234);
        rd(8'h1c);
        chk("soft_flags", 0, d & 32'h44);
        rdchk("soft_frame", 8'h28, 0);
        rdchk("soft_pid", 8'h2c, 0);
        rdchk("soft_ep", 8'h30, 0);
        chk("soft_rx_ep", 0, rx_ep_o);
        rdchk("soft_keep_addr", 8'h08, 32'h2a);
        rdchk("soft_keep_func", 8'h0c, 32'h9);
        tally_and_finish();
    end
endmodule

//--- sim/utmi_xcvr_model.sv
/*
 * Stand-in for the UTMI+ transceiver: status pins and serial receive
 * lines. Assumes the bench changes the pins through set_pins only.
 */
`timescale 1ns/1ns
module utmi_xcvr_model
(
    input  wire logic       sys_clk_i,
    input  wire logic       tx_se0_i,
    input  wire logic       tx_data_i,
    input  wire logic       tx_enable_n_i,
    output logic [1:0]      line_state_o,
    output logic            rx_active_o,
    output logic            rx_error_o,
    output logic [5:0]      otg_stat_o,
    output logic [2:0]      serial_rx_o
);
    localparam logic [2:0] idle_rx = 3'h1;
    initial
    begin
        line_state_o = 2'h1;
        rx_active_o  = 1'h0;
        rx_error_o   = 1'h0;
        otg_stat_o   = 6'h00;
    end
    // While the transmitter is on, the receivers echo the driven symbol.
    always_comb
    begin
        if (!tx_enable_n_i)
            serial_rx_o = tx_se0_i ? 3'h0 : {tx_data_i, ~tx_data_i, tx_data_i};
        else
            serial_rx_o = idle_rx;
    end
    task automatic set_pins(input logic [1:0] ls, input logic act,
                            input logic err, input logic [5:0] st);
        @(posedge sys_clk_i);
        line_state_o <= ls;
        rx_active_o  <= act;
        rx_error_o   <= err;
        otg_stat_o   <= st;
    endtask
endmodule
